// ---- icc_pkg.sv ----
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants and types of the input capture channel
// ---------------------------------------------------------------------------
package icc_pkg;

   // ------------------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00; // capture_channel_control
   localparam logic [ADDR_W-1:0] OFS_BUF = 8'h04; // Capture buffer, read pops.
   localparam logic [ADDR_W-1:0] OFS_IST = 8'h08; // Sticky interrupt status.
   localparam logic [ADDR_W-1:0] OFS_ICLR = 8'h0c; // Write one to clear.
   localparam logic [ADDR_W-1:0] OFS_IEN = 8'h10; // Interrupt enable.

   // ------------------------------------------------------------------------
   // Control register field positions
   // ------------------------------------------------------------------------
   localparam int BIT_IDLE = 13;
   localparam int BIT_TB = 7;
   localparam int BIT_RATE_HI = 6;
   localparam int BIT_RATE_LO = 5;
   localparam int BIT_OVF = 4;
   localparam int BIT_BNE = 3;
   localparam int BIT_MODE_HI = 2;
   localparam int BIT_MODE_LO = 0;

   // ------------------------------------------------------------------------
   // Interrupt status bits and buffer shape
   // ------------------------------------------------------------------------
   localparam int IRQ_W = 2;
   localparam int IRQ_CAP = 0; // Capture count reached.
   localparam int IRQ_WAKE = 1; // Wake edge during sleep or idle.
   localparam int BUF_DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] BUF_FULL = 3'h4;
   localparam logic [3:0] PRESC4_LAST = 4'h3;
   localparam logic [3:0] PRESC16_LAST = 4'hf;

   typedef enum logic [2:0] {
      MODE_OFF = 3'b000,
      MODE_ANY = 3'b001,
      MODE_FALL = 3'b010,
      MODE_RISE = 3'b011,
      MODE_P4 = 3'b100,
      MODE_P16 = 3'b101,
      MODE_UNUSED = 3'b110,
      MODE_WAKE = 3'b111
   } icc_mode_t;

   typedef struct packed {
      logic idle_halt_select;
      logic capture_timebase_select;
      logic [1:0] captures_per_interrupt;
      icc_mode_t capture_mode_select;
   } icc_ctrl_t;

   localparam icc_ctrl_t CTRL_RST = '{1'b0, 1'b0, 2'h0, MODE_OFF};

endpackage
`default_nettype wire

// ---- icc_edge_presc.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Edge detector and edge prescaler of the capture pin
// ---------------------------------------------------------------------------
module icc_edge_presc (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic pin_i,
   input var icc_pkg::icc_mode_t mode_i,
   output logic event_o,
   output logic wake_o
);

   logic pin_q;
   logic rise;
   logic fall;
   logic [3:0] presc;
   icc_pkg::icc_mode_t mode_q;
   logic next_event;

   // The pin is already synchronous, so one stage is enough to see edges.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_q <= 1'b0;
         mode_q <= icc_pkg::MODE_OFF;
      end else begin
         pin_q <= pin_i;
         mode_q <= mode_i;
      end
   end

   assign rise = pin_i & ~pin_q;
   assign fall = ~pin_i & pin_q;

   // Prescaler restarts on any mode change so a new ratio starts clean.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         presc <= 4'h0;
      end else if (mode_i != mode_q) begin
         presc <= 4'h0;
      end else if (rise && mode_i == icc_pkg::MODE_P4) begin
         presc <= (presc == icc_pkg::PRESC4_LAST) ? 4'h0 : presc + 4'h1;
      end else if (rise && mode_i == icc_pkg::MODE_P16) begin
         presc <= presc + 4'h1;
      end
   end

   // Decode the capture event for each mode.
   always_comb begin
      next_event = 1'b0;
      unique case (mode_i)
         icc_pkg::MODE_ANY: next_event = rise | fall;
         icc_pkg::MODE_FALL: next_event = fall;
         icc_pkg::MODE_RISE: next_event = rise;
         icc_pkg::MODE_P4: next_event = rise && presc == icc_pkg::PRESC4_LAST;
         icc_pkg::MODE_P16: next_event = rise && presc == icc_pkg::PRESC16_LAST;
         icc_pkg::MODE_OFF, icc_pkg::MODE_UNUSED, icc_pkg::MODE_WAKE: next_event = 1'b0;
      endcase
   end

   // Registered pulses, one cycle after the edge was seen.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         event_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         event_o <= next_event && mode_i == mode_q;
         wake_o <= rise && mode_i == icc_pkg::MODE_WAKE;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_p16_ratio: assert property (
      mode_i == icc_pkg::MODE_P16 && $past(mode_i) == icc_pkg::MODE_P16 && event_o
      |-> $past(presc) == icc_pkg::PRESC16_LAST && $past(rise))
      else $error("sixteen-edge capture fired early");
   a_p4_ratio: assert property (
      mode_i == icc_pkg::MODE_P4 && $past(mode_i) == icc_pkg::MODE_P4 && event_o
      |-> $past(presc) == icc_pkg::PRESC4_LAST && $past(rise))
      else $error("four-edge capture fired early");
   a_off_quiet: assert property (
      $past(mode_i) == icc_pkg::MODE_OFF |-> !event_o)
      else $error("capture event while channel off");

endmodule
`default_nettype wire

// ---- icc_capture.sv ----
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module icc_capture (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [icc_pkg::ADDR_W-1:0] addr_i,
   input wire logic [icc_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [icc_pkg::DATA_W-1:0] rdata_o,
   input wire logic cap_pin_i,
   input wire logic [icc_pkg::DATA_W-1:0] counter_a_i,
   input wire logic [icc_pkg::DATA_W-1:0] counter_b_i,
   input wire logic sleep_idle_i,
   output logic irq_o
);

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   icc_pkg::icc_ctrl_t ctrl;
   logic [icc_pkg::DATA_W-1:0] buf_mem [icc_pkg::BUF_DEPTH];
   logic [icc_pkg::PTR_W-1:0] wr_ptr;
   logic [icc_pkg::PTR_W-1:0] rd_ptr;
   logic [icc_pkg::CNT_W-1:0] count;
   logic ovf;
   logic bne;
   logic full;
   logic [1:0] rate_cnt;
   logic [icc_pkg::IRQ_W-1:0] irq_stat;
   logic [icc_pkg::IRQ_W-1:0] irq_en;
   logic cap_event;
   logic wake_edge;
   logic push;
   logic pop;
   logic cap_irq;
   logic wake_irq;
   logic wr_ctrl;
   logic wr_clr;
   logic wr_en;
   logic rd_buf;
   logic capturing;
   logic [icc_pkg::DATA_W-1:0] cap_word;
   logic [icc_pkg::DATA_W-1:0] next_rdata;

   // ------------------------------------------------------------------------
   // Pin edge handling
   // ------------------------------------------------------------------------

   // Edge detection and prescaling live in a leaf so the ratios stay local.
   icc_edge_presc u_edge (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .pin_i(cap_pin_i),
      .mode_i(ctrl.capture_mode_select),
      .event_o(cap_event),
      .wake_o(wake_edge)
   );

   // ------------------------------------------------------------------------
   // Register port decode
   // ------------------------------------------------------------------------

   // Strobes are one cycle long, so every decoded term is a one-cycle pulse.
   assign wr_ctrl = wr_i && addr_i == icc_pkg::OFS_CTRL;
   assign wr_clr = wr_i && addr_i == icc_pkg::OFS_ICLR;
   assign wr_en = wr_i && addr_i == icc_pkg::OFS_IEN;
   assign rd_buf = rd_i && addr_i == icc_pkg::OFS_BUF;

   // Control register; the two status bits are not stored here at all.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl <= icc_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl.idle_halt_select <= wdata_i[icc_pkg::BIT_IDLE];
         ctrl.capture_timebase_select <= wdata_i[icc_pkg::BIT_TB];
         ctrl.captures_per_interrupt <= wdata_i[icc_pkg::BIT_RATE_HI:icc_pkg::BIT_RATE_LO];
         ctrl.capture_mode_select <=
            icc_pkg::icc_mode_t'(wdata_i[icc_pkg::BIT_MODE_HI:icc_pkg::BIT_MODE_LO]);
      end
   end

   // ------------------------------------------------------------------------
   // Capture buffer
   // ------------------------------------------------------------------------

   // The wake mode never captures, even if an event slipped through a mode change.
   assign capturing = ctrl.capture_mode_select != icc_pkg::MODE_WAKE;
   assign full = count == icc_pkg::BUF_FULL;
   assign push = cap_event && capturing && !full;
   assign pop = rd_buf && bne;
   assign bne = count != '0;

   // Timebase choice is made at the capture edge, not when software reads.
   assign cap_word = ctrl.capture_timebase_select ? counter_a_i : counter_b_i;

   // Storage writes only; no reset needed for data words.
   always_ff @(posedge clk_i) begin
      if (push) begin
         buf_mem[wr_ptr] <= cap_word;
      end
   end

   // Pointers wrap naturally since the depth is a power of two.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 2'h1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 2'h1;
         end
         if (push && !pop) begin
            count <= count + 3'h1;
         end else if (pop && !push) begin
            count <= count - 3'h1;
         end
      end
   end

   // Overflow drops the new word and keeps the old ones. Hardware clears
   // it when the buffer is drained; a new overflow in that cycle wins.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ovf <= 1'b0;
      end else if (cap_event && capturing && full) begin
         ovf <= 1'b1;
      end else if (pop && count == 3'h1 && !push) begin
         ovf <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Interrupt generation
   // ------------------------------------------------------------------------

   // Both-edge mode ignores the rate field and interrupts on each capture.
   always_comb begin
      cap_irq = 1'b0;
      if (cap_event && capturing) begin
         cap_irq = ctrl.capture_mode_select == icc_pkg::MODE_ANY
                   || rate_cnt == ctrl.captures_per_interrupt;
      end
   end

   // Captures counted toward the rate; restarts whenever the channel is off.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rate_cnt <= 2'h0;
      end else if (ctrl.capture_mode_select == icc_pkg::MODE_OFF) begin
         rate_cnt <= 2'h0;
      end else if (cap_irq) begin
         rate_cnt <= 2'h0;
      end else if (cap_event && capturing) begin
         rate_cnt <= rate_cnt + 2'h1;
      end
   end

   // Wake edges count only while the device reports sleep or idle.
   assign wake_irq = wake_edge && sleep_idle_i &&
                     ctrl.capture_mode_select == icc_pkg::MODE_WAKE;

   // Sticky status; a new event beats a clear in the same cycle.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= (irq_stat & ~(wr_clr ? wdata_i[icc_pkg::IRQ_W-1:0] : '0))
                     | {wake_irq, cap_irq};
      end
   end

   // Enable register gates status onto the single level output.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_en <= '0;
      end else if (wr_en) begin
         irq_en <= wdata_i[icc_pkg::IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_stat & irq_en);

   // ------------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------------

   // Unmapped and write-only addresses read as zero.
   always_comb begin
      next_rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            icc_pkg::OFS_CTRL: begin
               next_rdata[icc_pkg::BIT_IDLE] = ctrl.idle_halt_select;
               next_rdata[icc_pkg::BIT_TB] = ctrl.capture_timebase_select;
               next_rdata[icc_pkg::BIT_RATE_HI:icc_pkg::BIT_RATE_LO] = ctrl.captures_per_interrupt;
               next_rdata[icc_pkg::BIT_OVF] = ovf;
               next_rdata[icc_pkg::BIT_BNE] = bne;
               next_rdata[icc_pkg::BIT_MODE_HI:icc_pkg::BIT_MODE_LO] = ctrl.capture_mode_select;
            end
            icc_pkg::OFS_BUF: next_rdata = bne ? buf_mem[rd_ptr] : '0;
            icc_pkg::OFS_IST: next_rdata[icc_pkg::IRQ_W-1:0] = irq_stat;
            icc_pkg::OFS_IEN: next_rdata[icc_pkg::IRQ_W-1:0] = irq_en;
            default: next_rdata = '0;
         endcase
      end
   end

   // Read data stands for exactly the cycle after the strobe.
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   a_timebase_word: assert property (
      push |=> buf_mem[$past(wr_ptr)] ==
         ($past(ctrl.capture_timebase_select) ? $past(counter_a_i) : $past(counter_b_i)))
      else $error("captured word came from the wrong counter");

   a_rate_fire: assert property (
      cap_event && capturing && ctrl.capture_mode_select != icc_pkg::MODE_ANY
      && rate_cnt == ctrl.captures_per_interrupt |=> irq_stat[icc_pkg::IRQ_CAP] && rate_cnt == 2'h0)
      else $error("capture interrupt missed at rate count");

   a_rate_hold: assert property (
      $rose(irq_stat[icc_pkg::IRQ_CAP]) |-> $past(cap_irq))
      else $error("capture interrupt without counted capture");

   a_ovf_set: assert property (
      cap_event && capturing && full |=> ovf && (count == icc_pkg::BUF_FULL || $past(pop)))
      else $error("overflow flag not set on full buffer");

   a_ovf_cause: assert property (
      $rose(ovf) |-> $past(cap_event && full))
      else $error("overflow flag set without overflow");

   a_bne_drain: assert property (
      pop && count == 3'h1 && !push |=> !bne ##1 (bne || !$past(pop)))
      else $error("buffer status stayed high after drain");

   a_wake_nocap: assert property (
      ctrl.capture_mode_select == icc_pkg::MODE_WAKE |-> !push)
      else $error("capture while in wake mode");

   a_wake_irq: assert property (
      wake_edge && sleep_idle_i && ctrl.capture_mode_select == icc_pkg::MODE_WAKE
      |=> irq_stat[icc_pkg::IRQ_WAKE])
      else $error("wake interrupt not raised");

   a_any_every: assert property (
      cap_event && ctrl.capture_mode_select == icc_pkg::MODE_ANY |=> irq_stat[icc_pkg::IRQ_CAP])
      else $error("both-edge mode skipped an interrupt");

   // Overflow bookkeeping: only a drain clears the flag, and software never sets it.
   a_ovf_keep: assert property (
      ovf && !(pop && count == 3'h1 && !push) |=> ovf)
      else $error("overflow flag dropped before drain");

   a_ovf_clear: assert property (
      pop && count == 3'h1 && !push |=> !ovf)
      else $error("overflow flag kept after drain");

   a_ovf_nowrite: assert property (
      wr_ctrl && !ovf && !(cap_event && capturing && full) |=> !ovf)
      else $error("software write set the overflow flag");

   a_drop_word: assert property (
      cap_event && capturing && full |=> wr_ptr == $past(wr_ptr))
      else $error("capture into full buffer was stored");

   a_count_bound: assert property (
      count <= icc_pkg::BUF_FULL)
      else $error("buffer count beyond depth");

   a_bne_push: assert property (
      push |=> bne)
      else $error("buffer status low after capture");

   a_pop_order: assert property (
      pop |=> rd_ptr == $past(rd_ptr) + 2'h1)
      else $error("buffer read did not advance");

   a_empty_read: assert property (
      rd_buf && !bne |=> rdata_o == '0 && rd_ptr == $past(rd_ptr))
      else $error("read of empty buffer returned data");

   a_rate_quiet: assert property (
      cap_event && capturing && ctrl.capture_mode_select != icc_pkg::MODE_ANY
      && rate_cnt != ctrl.captures_per_interrupt |-> !cap_irq)
      else $error("capture interrupt before rate count");

   a_rate_step: assert property (
      cap_event && capturing && !cap_irq && ctrl.capture_mode_select != icc_pkg::MODE_OFF
      |=> rate_cnt == $past(rate_cnt) + 2'h1)
      else $error("capture not counted toward the rate");

   a_stat_sticky: assert property (
      irq_stat[icc_pkg::IRQ_CAP] && !(wr_clr && wdata_i[icc_pkg::IRQ_CAP]) |=> irq_stat[icc_pkg::IRQ_CAP])
      else $error("capture interrupt status lost without clear");

   a_wake_awake: assert property (
      !wake_irq && !irq_stat[icc_pkg::IRQ_WAKE] |=> !irq_stat[icc_pkg::IRQ_WAKE])
      else $error("wake interrupt outside sleep or idle");

   a_wake_nocount: assert property (
      ctrl.capture_mode_select == icc_pkg::MODE_WAKE |-> !cap_irq)
      else $error("capture interrupt in wake mode");

   a_off_nocap: assert property (
      ctrl.capture_mode_select inside {icc_pkg::MODE_OFF, icc_pkg::MODE_UNUSED}
      && $stable(ctrl.capture_mode_select) |-> !push)
      else $error("capture while channel off or unused");

   c_fill_full: cover property (push ##1 push ##1 push ##1 push);
   c_overflow: cover property ($rose(ovf));
   c_rate_four: cover property (cap_irq && ctrl.captures_per_interrupt == 2'h3);
   c_wake: cover property (wake_irq ##1 irq_o);
   c_drain: cover property (pop && count == 3'h1 && ovf);

endmodule
`default_nettype wire

// ---- icc_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Model of the external signal source on the capture pin
// ---------------------------------------------------------------------------
module icc_pin_model (
   input wire logic clk_i,
   output logic pin_o
);
   // The pin idles low so that every pulse starts with a clean rising edge.
   initial begin
      pin_o = 1'b0;
   end

   // Each pulse gives one rising and one falling edge, two cycles apart.
   // The tail lets the two-cycle capture latency land before software looks.
   task automatic pulse(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         pin_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         pin_o <= 1'b0;
         @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ---- icc_capture_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) compare(got, exp)
// ---------------------------------------------------------------------------
// Self-checking bench of the input capture channel
// ---------------------------------------------------------------------------
module icc_capture_tb;
   logic clk_i;
   logic sys_rst_i;
   logic [icc_pkg::ADDR_W-1:0] addr_i;
   logic [icc_pkg::DATA_W-1:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [icc_pkg::DATA_W-1:0] rdata_o;
   wire logic cap_pin;
   logic [icc_pkg::DATA_W-1:0] counter_a_i;
   logic [icc_pkg::DATA_W-1:0] counter_b_i;
   logic sleep_idle_i;
   logic irq_o;
   logic [15:0] v;
   int fail_count;
   int checks;

   icc_capture dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_pin_i(cap_pin), .counter_a_i(counter_a_i),
      .counter_b_i(counter_b_i), .sleep_idle_i(sleep_idle_i), .irq_o(irq_o));
   icc_pin_model pin_u (.clk_i(clk_i), .pin_o(cap_pin));

   // ------------------------------------------------------------------------
   // Clock, comparison and bus tasks
   // ------------------------------------------------------------------------
   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Case equality keeps an unknown from passing as a match.
   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // A write occupies one strobe cycle; the next call waits for a fresh edge.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just then.
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      `CHK(d, exp);
   endtask

   // The interrupt is combinational from registers, so look just past the launching edge.
   task automatic irq_chk(input logic exp);
      #1;
      `CHK({15'h0, irq_o}, {15'h0, exp});
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the few hundred cycles the tests need.
   initial begin
      #400000;
      fail_count++;
      conclude();
   end

   // ------------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------------
   initial begin
      fail_count = 0;
      checks = 0;
      sys_rst_i = 1'b1;
      addr_i = '0;
      wdata_i = '0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      counter_a_i = 16'h1111;
      counter_b_i = 16'h2222;
      sleep_idle_i = 1'b0;
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;

      // Reset values, the stored-only field and unmapped places.
      rd_chk(icc_pkg::OFS_CTRL, 16'h0000);
      rd_chk(icc_pkg::OFS_IST, 16'h0000);
      rd_chk(8'h14, 16'h0000);
      rd_chk(icc_pkg::OFS_BUF, 16'h0000);
      wr(icc_pkg::OFS_CTRL, 16'h2000);
      rd_chk(icc_pkg::OFS_CTRL, 16'h2000);
      $display("test reset finished");

      // Timebase choice on rising edges; counters change so each word shows its source.
      wr(icc_pkg::OFS_CTRL, 16'h0083);
      counter_a_i <= 16'ha5c3;
      counter_b_i <= 16'h5a3c;
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_CTRL, 16'h008b);
      rd_chk(icc_pkg::OFS_BUF, 16'ha5c3);
      rd_chk(icc_pkg::OFS_CTRL, 16'h0083);
      wr(icc_pkg::OFS_CTRL, 16'h0003);
      counter_a_i <= 16'h0f0f;
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_BUF, 16'h5a3c);
      // Falling-edge mode takes one capture per pulse, both-edge mode two.
      wr(icc_pkg::OFS_CTRL, 16'h0002);
      counter_b_i <= 16'hffff;
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_BUF, 16'hffff);
      rd_chk(icc_pkg::OFS_CTRL, 16'h0002);
      wr(icc_pkg::OFS_CTRL, 16'h0001);
      counter_b_i <= 16'h8001;
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_BUF, 16'h8001);
      rd_chk(icc_pkg::OFS_BUF, 16'h8001);
      rd_chk(icc_pkg::OFS_CTRL, 16'h0001);
      $display("test edges finished");

      // Fifth capture into a full buffer; the status bits ignore writes.
      wr(icc_pkg::OFS_CTRL, 16'h0003);
      counter_b_i <= 16'h7ffe;
      pin_u.pulse(5);
      rd_chk(icc_pkg::OFS_CTRL, 16'h001b);
      wr(icc_pkg::OFS_CTRL, 16'h0003);
      rd_chk(icc_pkg::OFS_CTRL, 16'h001b);
      for (int i = 0; i < 4; i++) begin
         rd_chk(icc_pkg::OFS_BUF, 16'h7ffe);
      end
      rd_chk(icc_pkg::OFS_CTRL, 16'h0003);
      rd_chk(icc_pkg::OFS_BUF, 16'h0000);
      $display("test overflow finished");

      // Every rate code: no interrupt one capture short, then one.
      wr(icc_pkg::OFS_IEN, 16'h0001);
      for (int r = 0; r < 4; r++) begin
         wr(icc_pkg::OFS_CTRL, 16'h0000);
         wr(icc_pkg::OFS_ICLR, 16'h0003);
         wr(icc_pkg::OFS_CTRL, 16'(r << 5) | 16'h0003);
         pin_u.pulse(r);
         irq_chk(1'b0);
         pin_u.pulse(1);
         irq_chk(1'b1);
         rd_chk(icc_pkg::OFS_IST, 16'h0001);
         repeat (4) rd(icc_pkg::OFS_BUF, v);
      end
      // Both-edge mode interrupts at once whatever the rate field says.
      wr(icc_pkg::OFS_CTRL, 16'h0000);
      wr(icc_pkg::OFS_ICLR, 16'h0003);
      rd_chk(icc_pkg::OFS_IST, 16'h0000);
      wr(icc_pkg::OFS_CTRL, 16'h0061);
      pin_u.pulse(1);
      irq_chk(1'b1);
      repeat (2) rd(icc_pkg::OFS_BUF, v);
      $display("test rate finished");

      // Prescaled modes: nothing until the fourth or sixteenth rising edge.
      wr(icc_pkg::OFS_CTRL, 16'h0004);
      counter_b_i <= 16'h00ff;
      pin_u.pulse(3);
      rd_chk(icc_pkg::OFS_CTRL, 16'h0004);
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_CTRL, 16'h000c);
      rd_chk(icc_pkg::OFS_BUF, 16'h00ff);
      wr(icc_pkg::OFS_CTRL, 16'h0005);
      counter_b_i <= 16'hff00;
      pin_u.pulse(15);
      rd_chk(icc_pkg::OFS_CTRL, 16'h0005);
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_CTRL, 16'h000d);
      rd_chk(icc_pkg::OFS_BUF, 16'hff00);
      // Unused and off modes never capture.
      wr(icc_pkg::OFS_CTRL, 16'h0006);
      pin_u.pulse(2);
      rd_chk(icc_pkg::OFS_CTRL, 16'h0006);
      wr(icc_pkg::OFS_CTRL, 16'h0000);
      pin_u.pulse(2);
      rd_chk(icc_pkg::OFS_CTRL, 16'h0000);
      $display("test prescale finished");

      // Wake mode: an edge counts only in sleep or idle and never captures.
      wr(icc_pkg::OFS_ICLR, 16'h0003);
      wr(icc_pkg::OFS_IEN, 16'h0003);
      wr(icc_pkg::OFS_CTRL, 16'h00e7);
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_IST, 16'h0000);
      irq_chk(1'b0);
      @(posedge clk_i);
      sleep_idle_i <= 1'b1;
      pin_u.pulse(1);
      rd_chk(icc_pkg::OFS_IST, 16'h0002);
      irq_chk(1'b1);
      rd_chk(icc_pkg::OFS_CTRL, 16'h00e7);
      rd_chk(icc_pkg::OFS_BUF, 16'h0000);
      @(posedge clk_i);
      sleep_idle_i <= 1'b0;
      // Masking and clearing the interrupt.
      wr(icc_pkg::OFS_IEN, 16'h0000);
      irq_chk(1'b0);
      wr(icc_pkg::OFS_IEN, 16'h0002);
      irq_chk(1'b1);
      rd_chk(icc_pkg::OFS_IEN, 16'h0002);
      rd_chk(icc_pkg::OFS_ICLR, 16'h0000);
      wr(icc_pkg::OFS_ICLR, 16'h0002);
      irq_chk(1'b0);
      rd_chk(icc_pkg::OFS_IST, 16'h0000);
      $display("test wake finished");
      conclude();
   end
endmodule
`default_nettype wire
